// >>> wait_oneshot_defines.vh
`ifndef WAIT_ONESHOT_DEFINES_VH
`define WAIT_ONESHOT_DEFINES_VH

// register indices on the plain register port
`define ADDR_W 3
`define A_MODE 3'h0
`define A_PRESCALER 3'h1
`define A_SECONDARY 3'h2
`define A_PRIMARY 3'h3
`define A_WAVEFORM 3'h4
`define A_ONESHOT 3'h5
`define A_EXT_IRQ 3'h6
`define A_STATUS 3'h7

// timer_mode_reg fields
`define B_MODE_LO 4
`define B_MODE_HI 5
`define B_WRITE_CTRL 6
`define B_RUN 7
`define MODE_WAIT_ONESHOT 2'h3
`define MODE_TIMER 2'h0

// waveform_output_ctrl_reg fields
`define B_LEVEL_SEL 5
`define B_TRIG_EN 6
`define B_TRIG_EDGE 7

// oneshot_control_reg fields
`define B_START 0
`define B_SRC_LO 4
`define B_SRC_HI 5

// ext_irq_enable_reg fields
`define B_EXT_IN_EN 0
`define B_BOTH_EDGE 1

// status fields, write one to clear
`define B_ST_TIMER 0
`define B_ST_EXT 1

// count source codes
`define SRC_F1 2'h0
`define SRC_F2 2'h1
`define SRC_F8 2'h2
`define SRC_COMPANION 2'h3

`define RESET_BYTE 8'h00
`define PRESCALER_RESET 8'hff
`define PERIOD_RESET 8'hff
`define DIV8_LAST 3'h7

`endif

// >>> clock_source_divider.v
`timescale 1ns/1ns
`default_nettype none
`include "wait_oneshot_defines.vh"

// free-running divider giving one-cycle enables at f/2 and f/8
module clock_source_divider (
	input wire ref_clk_i,
	input wire rst_n_i,
	output reg tick_f2_o,
	output reg tick_f8_o
);

	reg [2:0] div_cnt;

	always @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			div_cnt <= 3'h0;
			tick_f2_o <= 1'b0;
			tick_f8_o <= 1'b0;
		end
		else
		begin
			div_cnt <= div_cnt + 3'h1;
			tick_f2_o <= div_cnt[0];
			tick_f8_o <= (div_cnt == `DIV8_LAST);
		end
	end

endmodule // clock_source_divider
`default_nettype wire

// >>> trigger_edge_detector.v
`timescale 1ns/1ns
`default_nettype none
`include "wait_oneshot_defines.vh"

// pin synchroniser followed by a selectable edge detector
module trigger_edge_detector (
	input wire ref_clk_i,
	input wire rst_n_i,
	input wire pin_i,
	input wire rising_sel_i,
	input wire both_edge_i,
	output wire trig_edge_o,
	output wire irq_edge_o
);

	reg meta;
	reg sync;
	reg last;
	wire rise;
	wire fall;

	always @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta <= 1'b1;
			sync <= 1'b1;
			last <= 1'b1;
		end
		else
		begin
			meta <= pin_i;
			sync <= meta;
			last <= sync;
		end
	end

	assign rise = sync & ~last;
	assign fall = ~sync & last;
	// polarity select only counts in single-edge operation
	assign trig_edge_o = both_edge_i ? (rise | fall) : (rising_sel_i ? rise : fall);
	assign irq_edge_o = trig_edge_o;

endmodule // trigger_edge_detector
`default_nettype wire

// >>> wait_oneshot_pulse_timer.v
// Functional notes
// - trigger by software or pin gives one pulse
// - wait primary period, then secondary-length pulse
// - count source f1, f2, f8 or companion
// - count down prescaler and primary period
// - primary underflow loads secondary, keeps counting
// - secondary underflow reloads primary, clears start bit
// - stopping reloads counters from reload registers
// - wait lasts (n+1)(m+1) source periods
// - pulse lasts (n+1)(p+1) source periods
// - start by writing start bit or trigger
// - stop at end, run flag 0, start 0
// - timer request raised as pulse ends
// - pin carries pulse; port only in timer mode
// - trigger enable adds the pin trigger; pin interrupt fires either way
// - primary period and prescaler reads give live count
// - period and prescaler writes touch reload only
// - output level select picks pulse level
// - edge polarity only in single-edge operation
// - hardware trigger needs three enables; busy ignores
// - level 0 high pulse; level 1 low pulse
// - polarity 0 falling edge, 1 rising edge
`timescale 1ns/1ns
`default_nettype none
`include "wait_oneshot_defines.vh"

module wait_oneshot_pulse_timer (
	input wire ref_clk_i,
	input wire rst_n_i,
	input wire [`ADDR_W-1:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [7:0] reg_rdata_o,
	input wire companion_uflow_i,
	input wire ext_trigger_pin_i,
	output reg pulse_out_pin_o,
	output reg pulse_out_oe_o,
	output reg timer_irq_o,
	output reg ext_irq_o
);

	localparam PH_WAIT = 1'b0;
	localparam PH_PULSE = 1'b1;

	reg rst_meta;
	reg rst_n;

	reg [7:0] timer_mode_reg;
	reg [7:0] waveform_output_ctrl_reg;
	reg [7:0] ext_irq_enable_reg;
	reg [1:0] src_sel;
	reg [7:0] prescaler_reg;
	reg [7:0] primary_period_reg;
	reg [7:0] secondary_period_reg;
	reg [1:0] status;

	reg [7:0] pre_cnt;
	reg [7:0] per_cnt;
	reg phase;
	reg oneshot_start_bit;

	reg [7:0] next_pre_cnt;
	reg [7:0] next_per_cnt;
	reg next_phase;
	reg next_start;
	reg next_timer_irq;
	reg [7:0] next_rdata;

	wire tick_f2;
	wire tick_f8;
	wire trig_edge;
	wire irq_edge;
	wire count_run_flag;
	wire wait_mode;
	wire output_level_sel;
	wire ext_trigger_enable;
	wire ext_input_enable;
	wire src_tick;
	wire wr_start_1;
	wire wr_start_0;
	wire hw_trigger;
	wire begin_count;
	wire stop_now;

	function wr_hit;
		input [`ADDR_W-1:0] a;
		begin
			wr_hit = reg_wr_i && (reg_addr_i == a);
		end
	endfunction

	// field and strobe decodes shared by several processes
	function [1:0] mode_bits;
		input [7:0] m;
		begin
			mode_bits = {m[`B_MODE_HI], m[`B_MODE_LO]};
		end
	endfunction

	function at_zero;
		input [7:0] c;
		begin
			at_zero = (c == 8'h00);
		end
	endfunction

	function clr_hit;
		input integer b;
		begin
			clr_hit = wr_hit(`A_STATUS) && reg_wdata_i[b];
		end
	endfunction

	// reset is released synchronously so no flop sees a partial release
	always @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	clock_source_divider u_div (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n),
		.tick_f2_o(tick_f2),
		.tick_f8_o(tick_f8)
	);

	trigger_edge_detector u_trig (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n),
		.pin_i(ext_trigger_pin_i),
		.rising_sel_i(waveform_output_ctrl_reg[`B_TRIG_EDGE]),
		.both_edge_i(ext_irq_enable_reg[`B_BOTH_EDGE]),
		.trig_edge_o(trig_edge),
		.irq_edge_o(irq_edge)
	);

	assign count_run_flag = timer_mode_reg[`B_RUN];
	assign wait_mode = (mode_bits(timer_mode_reg) == `MODE_WAIT_ONESHOT);
	assign output_level_sel = waveform_output_ctrl_reg[`B_LEVEL_SEL];
	assign ext_trigger_enable = waveform_output_ctrl_reg[`B_TRIG_EN];
	assign ext_input_enable = ext_irq_enable_reg[`B_EXT_IN_EN];

	// companion underflow arrives from logic on this same clock
	assign src_tick = (src_sel == `SRC_F1) ? 1'b1 :
		(src_sel == `SRC_F2) ? tick_f2 :
		(src_sel == `SRC_F8) ? tick_f8 : companion_uflow_i;

	assign wr_start_1 = wr_hit(`A_ONESHOT) && reg_wdata_i[`B_START];
	assign wr_start_0 = wr_hit(`A_ONESHOT) && !reg_wdata_i[`B_START];
	// a trigger during a count is dropped; the interrupt path still fires
	assign hw_trigger = trig_edge && count_run_flag && ext_input_enable
		&& ext_trigger_enable && !oneshot_start_bit;
	assign begin_count = wait_mode && count_run_flag && !oneshot_start_bit
		&& (wr_start_1 || hw_trigger);
	assign stop_now = oneshot_start_bit && (wr_start_0
		|| (wr_hit(`A_MODE) && !reg_wdata_i[`B_RUN]) || !wait_mode);

	// software registers; the mode bits are only stored, software picks 11
	always @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			timer_mode_reg <= `RESET_BYTE;
			waveform_output_ctrl_reg <= `RESET_BYTE;
			ext_irq_enable_reg <= `RESET_BYTE;
			src_sel <= `SRC_F1;
			prescaler_reg <= `PRESCALER_RESET;
			primary_period_reg <= `PERIOD_RESET;
			secondary_period_reg <= `PERIOD_RESET;
		end
		else
		begin
			if (wr_hit(`A_MODE))
				timer_mode_reg <= reg_wdata_i;
			if (wr_hit(`A_WAVEFORM))
				waveform_output_ctrl_reg <= reg_wdata_i;
			if (wr_hit(`A_EXT_IRQ))
				ext_irq_enable_reg <= reg_wdata_i;
			if (wr_hit(`A_ONESHOT))
				src_sel <= reg_wdata_i[`B_SRC_HI:`B_SRC_LO];
			// writes land in the reload copies only
			if (wr_hit(`A_PRESCALER))
				prescaler_reg <= reg_wdata_i;
			if (wr_hit(`A_PRIMARY))
				primary_period_reg <= reg_wdata_i;
			if (wr_hit(`A_SECONDARY))
				secondary_period_reg <= reg_wdata_i;
		end
	end

	// counter next state
	always @*
	begin
		next_pre_cnt = pre_cnt;
		next_per_cnt = per_cnt;
		next_phase = phase;
		next_start = oneshot_start_bit;
		next_timer_irq = 1'b0;
		if (begin_count)
		begin
			// primary period takes effect at the next shot; prescaler and secondary reload mid-shot
			next_pre_cnt = prescaler_reg;
			next_per_cnt = primary_period_reg;
			next_phase = PH_WAIT;
			next_start = 1'b1;
		end
		else if (stop_now)
		begin
			next_pre_cnt = prescaler_reg;
			next_per_cnt = primary_period_reg;
			next_phase = PH_WAIT;
			next_start = 1'b0;
		end
		else if (oneshot_start_bit && src_tick)
		begin
			if (!at_zero(pre_cnt))
				next_pre_cnt = pre_cnt - 8'h01;
			else
			begin
				next_pre_cnt = prescaler_reg;
				if (!at_zero(per_cnt))
					next_per_cnt = per_cnt - 8'h01;
				else
				begin
					case (phase)
						PH_WAIT:
						begin
							next_per_cnt = secondary_period_reg;
							next_phase = PH_PULSE;
						end
						PH_PULSE:
						begin
							next_per_cnt = primary_period_reg;
							next_phase = PH_WAIT;
							next_start = 1'b0;
							next_timer_irq = 1'b1;
						end
						default:
						begin
							next_phase = PH_WAIT;
						end
					endcase
				end
			end
		end
	end

	always @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pre_cnt <= `PRESCALER_RESET;
			per_cnt <= `PERIOD_RESET;
			phase <= PH_WAIT;
			oneshot_start_bit <= 1'b0;
			timer_irq_o <= 1'b0;
			ext_irq_o <= 1'b0;
			pulse_out_pin_o <= 1'b0;
			pulse_out_oe_o <= 1'b0;
		end
		else
		begin
			pre_cnt <= next_pre_cnt;
			per_cnt <= next_per_cnt;
			phase <= next_phase;
			oneshot_start_bit <= next_start;
			// request comes with the cycle in which the pulse ends
			timer_irq_o <= next_timer_irq;
			ext_irq_o <= irq_edge && ext_input_enable;
			// pulse level flips against the idle level
			pulse_out_pin_o <= output_level_sel
				^ (next_start && next_phase == PH_PULSE);
			// timer mode hands the pin back to the port logic
			pulse_out_oe_o <= (mode_bits(timer_mode_reg) != `MODE_TIMER);
		end
	end

	// sticky request flags; a new event beats a same-cycle clear
	always @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			status <= 2'h0;
		else
		begin
			if (next_timer_irq)
				status[`B_ST_TIMER] <= 1'b1;
			else if (clr_hit(`B_ST_TIMER))
				status[`B_ST_TIMER] <= 1'b0;
			if (irq_edge && ext_input_enable)
				status[`B_ST_EXT] <= 1'b1;
			else if (clr_hit(`B_ST_EXT))
				status[`B_ST_EXT] <= 1'b0;
		end
	end

	// read mux; unmapped bits read zero
	always @*
	begin
		next_rdata = 8'h00;
		case (reg_addr_i)
			`A_MODE: next_rdata = timer_mode_reg;
			`A_PRESCALER: next_rdata = pre_cnt;
			`A_SECONDARY: next_rdata = secondary_period_reg;
			`A_PRIMARY: next_rdata = per_cnt;
			`A_WAVEFORM: next_rdata = waveform_output_ctrl_reg;
			`A_ONESHOT:
			begin
				next_rdata[`B_START] = oneshot_start_bit;
				next_rdata[`B_SRC_HI:`B_SRC_LO] = src_sel;
			end
			`A_EXT_IRQ: next_rdata = ext_irq_enable_reg;
			`A_STATUS: next_rdata[`B_ST_EXT:`B_ST_TIMER] = status;
			default: next_rdata = 8'h00;
		endcase
	end

	// read data stands only in the cycle after the strobe
	always @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata_o <= 8'h00;
		else if (reg_rd_i)
			reg_rdata_o <= next_rdata;
		else
			reg_rdata_o <= 8'h00;
	end

endmodule // wait_oneshot_pulse_timer
`default_nettype wire

// >>> timer_checker_sva.sv
`timescale 1ns/1ns
`default_nettype none
`include "wait_oneshot_defines.vh"
module timer_checker (
	input wire ref_clk_i,
	input wire rst_n_i,
	input wire [`ADDR_W-1:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	input wire [7:0] reg_rdata_o,
	input wire companion_uflow_i,
	input wire ext_trigger_pin_i,
	input wire pulse_out_pin_o,
	input wire pulse_out_oe_o,
	input wire timer_irq_o,
	input wire ext_irq_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	wire mode_wr = reg_wr_i && reg_addr_i == `A_MODE;
	property p_rd_idle; !$past(reg_rd_i) |-> reg_rdata_o == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
	property p_irq_one; timer_irq_o |=> !timer_irq_o; endproperty
	a_irq_one: assert property (p_irq_one) else $error("timer request too long");
	property p_irq_end; $rose(timer_irq_o) |-> $changed(pulse_out_pin_o); endproperty
	a_irq_end: assert property (p_irq_end) else $error("request not at pulse end");
	property p_irq_oe; timer_irq_o |-> pulse_out_oe_o; endproperty
	a_irq_oe: assert property (p_irq_oe) else $error("request with pin as port");
	property p_ext_one; ext_irq_o |=> !ext_irq_o; endproperty
	a_ext_one: assert property (p_ext_one) else $error("pin request too long");
	// a pin request needs a pin change a few cycles earlier
	property p_ext_cause;
		ext_irq_o |-> $past(ext_trigger_pin_i, 2) != $past(ext_trigger_pin_i, 8);
	endproperty
	a_ext_cause: assert property (p_ext_cause) else $error("pin request without edge");
	property p_port; mode_wr && reg_wdata_i[5:4] == 2'h0 |-> ##[1:2] !pulse_out_oe_o; endproperty
	a_port: assert property (p_port) else $error("pin driven in timer mode");
	property p_drive; mode_wr && reg_wdata_i[5:4] == 2'h3 |-> ##[1:2] pulse_out_oe_o; endproperty
	a_drive: assert property (p_drive) else $error("pin not driven");
endmodule // timer_checker
bind wait_oneshot_pulse_timer timer_checker chk (.ref_clk_i, .rst_n_i, .reg_addr_i,
	.reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .companion_uflow_i,
	.ext_trigger_pin_i, .pulse_out_pin_o, .pulse_out_oe_o, .timer_irq_o, .ext_irq_o);
`default_nettype wire

// >>> trigger_source_load.sv
`timescale 1ns/1ns
`default_nettype none
module trigger_source_load (
	input wire logic ref_clk_i,
	input wire logic fire_i,
	input wire logic pulse_i,
	input wire logic oe_i,
	output logic trig_pin_o,
	output var logic [7:0] edges_o = 8'h00
);
	logic [3:0] hold = 4'h0;
	logic prev = 1'b0;
	always @(posedge ref_clk_i)
	begin
		prev <= pulse_i;
		if (oe_i && pulse_i != prev)
			edges_o <= edges_o + 8'h01;
		if (fire_i && hold == 4'h0)
			hold <= 4'hc;
		else if (hold != 4'h0)
			hold <= hold - 4'h1;
	end
	// idle high; held low long enough for the synchroniser to see both edges
	assign trig_pin_o = (hold == 4'h0);
endmodule // trigger_source_load
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "wait_oneshot_defines.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
	$display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module testbench;
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [`ADDR_W-1:0] reg_addr_i = 3'h0;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic companion_uflow_i = 1'b0;
	logic fire = 1'b0;
	logic [1:0] phase = 2'h0;
	logic [7:0] d;
	wire [7:0] reg_rdata_o;
	wire [7:0] edges;
	wire ext_trigger_pin_i, pulse_out_pin_o, pulse_out_oe_o, timer_irq_o, ext_irq_o;
	int bad_count = 0;
	int checked = 0;
	int ext_seen = 0;
	int n, e0, x0;
	int mult[4] = '{1, 2, 8, 4};
	wait_oneshot_pulse_timer wait_oneshot_pulse_timer_inst (.ref_clk_i, .rst_n_i,
		.reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .companion_uflow_i,
		.ext_trigger_pin_i, .pulse_out_pin_o, .pulse_out_oe_o, .timer_irq_o, .ext_irq_o);
	trigger_source_load trigger_source_load_inst (.ref_clk_i, .fire_i(fire),
		.pulse_i(pulse_out_pin_o), .oe_i(pulse_out_oe_o), .trig_pin_o(ext_trigger_pin_i),
		.edges_o(edges));
	initial forever #20 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i)
	begin
		phase <= phase + 2'h1;
		companion_uflow_i <= (phase == 2'h3);
		if (ext_irq_o === 1'b1)
			ext_seen++;
	end
	task automatic conclude;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_wr_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b0;
		#1 v = reg_rdata_o;
	endtask
	// counts edges until the pin leaves its present level
	task automatic wait_pin(output int c);
		logic v;
		#1 v = pulse_out_pin_o;
		c = 0;
		while (pulse_out_pin_o === v && c < 3000)
		begin
			@(posedge ref_clk_i);
			#1 c++;
		end
		if (c >= 3000)
		begin
			bad_count++;
			conclude();
		end
	endtask
	task automatic kick;
		@(posedge ref_clk_i);
		fire <= 1'b1;
		@(posedge ref_clk_i);
		fire <= 1'b0;
	endtask
	initial
	begin
		repeat (8) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		rd(`A_PRESCALER, d);
		`CHK(d, 8'hff)
		wr(`A_PRESCALER, 8'h01);
		wr(`A_PRIMARY, 8'h02);
		wr(`A_SECONDARY, 8'h03);
		wr(`A_MODE, 8'hf0);
		for (int s = 0; s < 4; s++)
		begin
			wr(`A_WAVEFORM, {2'h0, s[0], 5'h00});
			wr(`A_ONESHOT, {2'h0, s[1:0], 4'h1});
			wait_pin(n);
			if (s == 0)
				`CHK(n, 6)
			`CHK(pulse_out_pin_o, ~s[0])
			wait_pin(n);
			`CHK(n, mult[s] * 8)
			`CHK(timer_irq_o, 1'b1)
			rd(`A_ONESHOT, d);
			`CHK(d[0], 1'b0)
		end
		wr(`A_WAVEFORM, 8'h00);
		wr(`A_PRESCALER, 8'h00);
		wr(`A_PRIMARY, 8'hc8);
		wr(`A_ONESHOT, 8'h01);
		rd(`A_PRIMARY, d);
		`CHK(d < 8'hc8 && d > 8'hb0, 1'b1)
		wr(`A_PRIMARY, 8'h05);
		rd(`A_PRIMARY, d);
		`CHK(d > 8'h05, 1'b1)
		wr(`A_ONESHOT, 8'h00);
		rd(`A_PRIMARY, d);
		`CHK(d, 8'h05)
		`CHK(pulse_out_pin_o, 1'b0)
		wr(`A_ONESHOT, 8'h01);
		wr(`A_MODE, 8'h70);
		rd(`A_PRIMARY, d);
		`CHK(d, 8'h05)
		wr(`A_MODE, 8'hf0);
		wr(`A_SECONDARY, 8'h1f);
		wr(`A_EXT_IRQ, 8'h01);
		wr(`A_WAVEFORM, 8'h40);
		x0 = ext_seen;
		e0 = edges;
		kick();
		wait_pin(n);
		`CHK(n, 9)
		repeat (6) @(posedge ref_clk_i);
		kick();
		wait_pin(n);
		repeat (30) @(posedge ref_clk_i);
		`CHK(edges - e0, 2)
		`CHK(ext_seen - x0, 2)
		wr(`A_WAVEFORM, 8'hc0);
		kick();
		wait_pin(n);
		`CHK(n, 21)
		wait_pin(n);
		`CHK(n, 32)
		wr(`A_WAVEFORM, 8'h00);
		wr(`A_EXT_IRQ, 8'h03);
		wr(`A_STATUS, 8'h03);
		x0 = ext_seen;
		e0 = edges;
		kick();
		repeat (20) @(posedge ref_clk_i);
		`CHK(ext_seen - x0, 2)
		`CHK(edges - e0, 0)
		rd(`A_STATUS, d);
		`CHK(d, 8'h02)
		wr(`A_STATUS, 8'h02);
		rd(`A_STATUS, d);
		`CHK(d, 8'h00)
		wr(`A_MODE, 8'h00);
		repeat (3) @(posedge ref_clk_i);
		`CHK(pulse_out_oe_o, 1'b0)
		conclude();
	end
endmodule // testbench
`default_nettype wire
